// *** shared/intc_defines.vh ***
// Register map, field positions and reset values of the CPU interrupt
// priority controller. Included by the controller and its bench.
`ifndef INTC_DEFINES_VH
`define INTC_DEFINES_VH

// Byte addresses on the APB register bus
`define INTC_ADDR_W              12
`define INTC_INTERRUPT_CONTROL_A 12'h000
`define INTC_HIGH_VECTOR_SELECT  12'h004
`define INTC_SOURCE_ENABLE       12'h008
`define INTC_LEVEL_STATUS        12'h00c
`define INTC_PENDING             12'h010
`define INTC_LAST_NORMAL         12'h014

// Field positions
`define INTC_ROTATE_ENABLE_BIT   0
`define INTC_STATUS_NORMAL_BIT   0
`define INTC_STATUS_HIGH_BIT     1
`define INTC_STATUS_NMI_BIT      2

// Reset values
`define INTC_CONTROL_A_RESET     1'h0
`define INTC_HIGH_VECTOR_RESET   8'h00

// Level codes presented to the core
`define INTC_LEVEL_NORMAL        2'h0
`define INTC_LEVEL_HIGH          2'h1
`define INTC_LEVEL_NMI           2'h2

`endif

// *** rtl/lowest_request_picker.v ***
// Lowest-index request finder used for all fixed-order arbitration.
// Assumes a plain request vector; purely combinational.
`timescale 1ns/10ps

module lowest_request_picker #(
    parameter W  = 16,
    parameter IW = 4
) (
    input  wire [W-1:0]  req,
    output reg           found,
    output reg  [IW-1:0] index
);
    integer i;

    // Scan downward so the lowest set bit is the last one written
    always @* begin
        found = 1'b0;
        index = {IW{1'b0}};
        for (i = W - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                index = i[IW-1:0];
            end
        end
    end
endmodule // lowest_request_picker

// *** rtl/rotating_request_picker.v ***
// Normal-level arbiter: fixed lowest-index order, or rotation that
// starts just above the last granted index. Combinational only.
`timescale 1ns/10ps

module rotating_request_picker #(
    parameter W  = 16,
    parameter IW = 4
) (
    input  wire [W-1:0]  req,
    input  wire [IW-1:0] last,
    input  wire          rotate,
    output wire          found,
    output wire [IW-1:0] index
);
    wire [W-1:0]  above;
    wire [W-1:0]  upper_req;
    wire          upper_found;
    wire [IW-1:0] upper_index;
    wire [IW-1:0] base_index;
    genvar g;

    // Sources ranked after the last winner
    generate
        for (g = 0; g < W; g = g + 1) begin : g_above
            assign above[g] = (g > last);
        end
    endgenerate

    assign upper_req = req & above & {W{rotate}};

    lowest_request_picker #(.W(W), .IW(IW)) u_upper (
        .req   (upper_req),
        .found (upper_found),
        .index (upper_index)
    );

    lowest_request_picker #(.W(W), .IW(IW)) u_base (
        .req   (req),
        .found (found),
        .index (base_index)
    );

    // Wrap to the lowest index when nothing sits above the last winner
    assign index = upper_found ? upper_index : base_index;
endmodule // rotating_request_picker

// *** rtl/cpu_interrupt_controller.v ***
// CPU interrupt controller: level and priority logic between peripheral
// requests and the core, with an APB register slave on the same clock.
// Assumes requests, global enable, ack and return come from pclk logic.
//
// Contract
// - After reset every maskable source sits on the normal level.
// - One source chosen by vector select is raised above all normal sources.
// - A pending high-level request pre-empts a running normal handler.
// - Returning from the high handler resumes the interrupted normal handler.
// - NMI is taken regardless of global enable and never alters it.
// - Nothing pre-empts a running NMI handler.
// - Among simultaneous NMIs the lowest vector address wins.
// - NMI set is fixed by the device; NMIs still need enabling.
// - Each source dispatches to its own fixed vector address.
// - Static normal priority: lowest pending vector address wins.
// - Writing one to rotate enable in control A selects round-robin.
// - Round-robin affects only normal-level requests.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "intc_defines.vh"

module cpu_interrupt_controller #(
    parameter        NUM_SOURCES   = 16,
    parameter        IDX_W         = 4,
    // Which sources are non-maskable; fixed at build time
    parameter [15:0] NMI_SOURCES   = 16'h0001,
    // Vector number of source 0; vector 0 stays the reset entry
    parameter [7:0]  VECTOR_FIRST  = 8'h01,
    // Address step between consecutive vectors
    parameter [7:0]  VECTOR_STEP   = 8'h02
) (
    input  wire                          pclk,
    input  wire                          presetn,
    input  wire [`INTC_ADDR_W-1:0]       paddr,
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [31:0]                   pwdata,
    output reg  [31:0]                   prdata,
    output reg                           pready,
    output reg                           pslverr,
    input  wire [NUM_SOURCES-1:0]        irq_request,
    input  wire                          global_int_enable,
    input  wire                          irq_ack,
    input  wire                          irq_return,
    output reg                           irq_valid,
    output reg  [7:0]                    irq_vector,
    output reg  [15:0]                   irq_vector_address,
    output reg  [1:0]                    irq_level
);
    localparam [31:0] LAST_RESET = NUM_SOURCES - 1;

    // Software-visible state
    reg                    normal_level_rotate_enable;
    reg  [7:0]             high_level_vector_select;
    reg  [NUM_SOURCES-1:0] source_enable;

    // Execution state of the core, as tracked here
    reg                    normal_active;
    reg                    high_active;
    reg                    nmi_active;
    reg  [IDX_W-1:0]       last_normal;

    // Next values of the offer and level tracking
    reg                    next_valid;
    reg  [7:0]             next_vector;
    reg  [1:0]             next_level;
    reg  [IDX_W-1:0]       next_source;
    reg  [IDX_W-1:0]       offer_source;
    reg                    next_normal_active;
    reg                    next_high_active;
    reg                    next_nmi_active;
    reg  [IDX_W-1:0]       next_last_normal;

    // Request classification
    wire [NUM_SOURCES-1:0] pending;
    wire [NUM_SOURCES-1:0] nmi_mask;
    wire [NUM_SOURCES-1:0] nmi_pending;
    wire [NUM_SOURCES-1:0] maskable_pending;
    wire [NUM_SOURCES-1:0] high_onehot;
    wire [NUM_SOURCES-1:0] high_pending;
    wire [NUM_SOURCES-1:0] normal_pending;
    wire                   high_found;
    wire [IDX_W-1:0]       high_index;
    wire                   nmi_found;
    wire [IDX_W-1:0]       nmi_index;
    wire                   normal_found;
    wire [IDX_W-1:0]       normal_index;

    // APB decode
    wire                   apb_access;
    wire                   apb_done;
    wire                   addr_hit;
    reg  [31:0]            read_mux;
    genvar g;

    // A source must be enabled before it counts, NMI included
    assign pending     = irq_request & source_enable;
    assign nmi_mask    = NMI_SOURCES[NUM_SOURCES-1:0];

    // NMIs ignore the global enable; it is only read, never driven
    assign nmi_pending = pending & nmi_mask;

    // Maskable requests need the global enable
    assign maskable_pending = pending & ~nmi_mask & {NUM_SOURCES{global_int_enable}};

    // Decode the selected high-level vector; zero selects nothing
    generate
        for (g = 0; g < NUM_SOURCES; g = g + 1) begin : g_high
            assign high_onehot[g] = ({24'h0, high_level_vector_select} == VECTOR_FIRST + g);
        end
    endgenerate

    assign high_pending   = maskable_pending & high_onehot;
    assign normal_pending = maskable_pending & ~high_onehot;

    // Only one bit of high_pending can be set, so any picker works
    lowest_request_picker #(.W(NUM_SOURCES), .IW(IDX_W)) u_high (
        .req   (high_pending),
        .found (high_found),
        .index (high_index)
    );

    // Fixed order among NMIs, never rotated
    lowest_request_picker #(.W(NUM_SOURCES), .IW(IDX_W)) u_nmi (
        .req   (nmi_pending),
        .found (nmi_found),
        .index (nmi_index)
    );

    // Normal arbitration: static by default, rotating when enabled
    rotating_request_picker #(.W(NUM_SOURCES), .IW(IDX_W)) u_normal (
        .req    (normal_pending),
        .last   (last_normal),
        .rotate (normal_level_rotate_enable),
        .found  (normal_found),
        .index  (normal_index)
    );

    // Pick what to offer the core, highest level first
    always @* begin
        next_valid   = 1'b0;
        next_level   = `INTC_LEVEL_NORMAL;
        offer_source = {IDX_W{1'b0}};
        if (nmi_found && !nmi_active) begin
            next_valid   = 1'b1;
            next_level   = `INTC_LEVEL_NMI;
            offer_source = nmi_index;
        end else if (high_found && !nmi_active && !high_active) begin
            // May land on top of a running normal handler
            next_valid   = 1'b1;
            next_level   = `INTC_LEVEL_HIGH;
            offer_source = high_index;
        end else if (normal_found && !nmi_active && !high_active
                     && !normal_active) begin
            next_valid   = 1'b1;
            next_level   = `INTC_LEVEL_NORMAL;
            offer_source = normal_index;
        end
        next_source = offer_source;
        next_vector = VECTOR_FIRST + {{(8-IDX_W){1'b0}}, offer_source};
    end

    // Level bookkeeping: return pops the top level, ack pushes the new one
    always @* begin
        next_normal_active = normal_active;
        next_high_active   = high_active;
        next_nmi_active    = nmi_active;
        next_last_normal   = last_normal;
        if (irq_return) begin
            if (nmi_active) begin
                next_nmi_active = 1'b0;
            end else if (high_active) begin
                // Normal handler underneath stays marked and resumes
                next_high_active = 1'b0;
            end else begin
                next_normal_active = 1'b0;
            end
        end
        if (irq_ack && irq_valid) begin
            case (irq_level)
                `INTC_LEVEL_NMI: begin
                    next_nmi_active = 1'b1;
                end
                `INTC_LEVEL_HIGH: begin
                    next_high_active = 1'b1;
                end
                `INTC_LEVEL_NORMAL: begin
                    next_normal_active = 1'b1;
                    next_last_normal   = irq_vector[IDX_W-1:0] - VECTOR_FIRST[IDX_W-1:0];
                end
                default: begin
                    next_normal_active = normal_active;
                end
            endcase
        end
    end

    // Offer and level registers; an accepted offer drops for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_valid          <= 1'b0;
            irq_vector         <= 8'h00;
            irq_vector_address <= 16'h0000;
            irq_level          <= `INTC_LEVEL_NORMAL;
            normal_active      <= 1'b0;
            high_active        <= 1'b0;
            nmi_active         <= 1'b0;
            last_normal        <= LAST_RESET[IDX_W-1:0];
        end else begin
            normal_active <= next_normal_active;
            high_active   <= next_high_active;
            nmi_active    <= next_nmi_active;
            last_normal   <= next_last_normal;
            if (irq_ack && irq_valid) begin
                // Wait for the new level state before offering again
                irq_valid <= 1'b0;
            end else begin
                irq_valid          <= next_valid;
                irq_vector         <= next_vector;
                irq_vector_address <= {8'h00, next_vector} * {8'h00, VECTOR_STEP};
                irq_level          <= next_level;
            end
        end
    end

    // APB: one wait state so read data comes from a flip-flop
    assign apb_access = psel && penable && !pready;
    assign apb_done   = psel && penable && pready;
    assign addr_hit   = (paddr == `INTC_INTERRUPT_CONTROL_A)
                     || (paddr == `INTC_HIGH_VECTOR_SELECT)
                     || (paddr == `INTC_SOURCE_ENABLE)
                     || (paddr == `INTC_LEVEL_STATUS)
                     || (paddr == `INTC_PENDING)
                     || (paddr == `INTC_LAST_NORMAL);

    // Read data selection; unused upper bits read zero
    always @* begin
        read_mux = 32'h00000000;
        case (paddr)
            `INTC_INTERRUPT_CONTROL_A: begin
                read_mux[`INTC_ROTATE_ENABLE_BIT] = normal_level_rotate_enable;
            end
            `INTC_HIGH_VECTOR_SELECT: begin
                read_mux[7:0] = high_level_vector_select;
            end
            `INTC_SOURCE_ENABLE: begin
                read_mux[NUM_SOURCES-1:0] = source_enable;
            end
            `INTC_LEVEL_STATUS: begin
                read_mux[`INTC_STATUS_NORMAL_BIT] = normal_active;
                read_mux[`INTC_STATUS_HIGH_BIT]   = high_active;
                read_mux[`INTC_STATUS_NMI_BIT]    = nmi_active;
            end
            `INTC_PENDING: begin
                read_mux[NUM_SOURCES-1:0] = pending;
            end
            `INTC_LAST_NORMAL: begin
                read_mux[IDX_W-1:0] = last_normal;
            end
            default: begin
                read_mux = 32'h00000000;
            end
        endcase
    end

    // Bus handshake and read capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (apb_access) begin
            pready  <= 1'b1;
            pslverr <= !addr_hit;
            prdata  <= pwrite ? 32'h00000000 : read_mux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writes land only on the edge that completes the transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_level_rotate_enable <= `INTC_CONTROL_A_RESET;
            high_level_vector_select   <= `INTC_HIGH_VECTOR_RESET;
            source_enable              <= {NUM_SOURCES{1'b0}};
        end else if (apb_done && pwrite) begin
            case (paddr)
                `INTC_INTERRUPT_CONTROL_A: begin
                    normal_level_rotate_enable <= pwdata[`INTC_ROTATE_ENABLE_BIT];
                end
                `INTC_HIGH_VECTOR_SELECT: begin
                    high_level_vector_select <= pwdata[7:0];
                end
                `INTC_SOURCE_ENABLE: begin
                    source_enable <= pwdata[NUM_SOURCES-1:0];
                end
                default: begin
                    // Status registers are read-only; writes are dropped
                    source_enable <= source_enable;
                end
            endcase
        end
    end
endmodule // cpu_interrupt_controller

// *** testbench/intc_properties.sv ***
// Port assertions for the interrupt controller: APB answer and offers.
// Assumes one pclk domain with asynchronous active-low presetn.
`timescale 1ns/10ps
`include "intc_defines.vh"

module intc_properties #(
    parameter [7:0] VECTOR_FIRST = 8'h01,
    parameter [7:0] VECTOR_STEP  = 8'h02
) (
    input wire                    pclk,
    input wire                    presetn,
    input wire [`INTC_ADDR_W-1:0] paddr,
    input wire                    psel,
    input wire                    penable,
    input wire                    pwrite,
    input wire [31:0]             pwdata,
    input wire                    pready,
    input wire                    pslverr,
    input wire                    global_int_enable,
    input wire                    irq_ack,
    input wire                    irq_return,
    input wire                    irq_valid,
    input wire [7:0]              irq_vector,
    input wire [15:0]             irq_vector_address,
    input wire [1:0]              irq_level
);
    reg  nmi_on;
    reg  high_on;
    reg  norm_on;
    reg  high_chosen;
    wire took = irq_ack && irq_valid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Handler stack as the core sees it; a return pops the top level first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_on      <= 1'b0;
            high_on     <= 1'b0;
            norm_on     <= 1'b0;
            high_chosen <= 1'b0;
        end else begin
            if (irq_return && nmi_on)
                nmi_on <= 1'b0;
            else if (irq_return && high_on)
                high_on <= 1'b0;
            else if (irq_return)
                norm_on <= 1'b0;
            if (took && irq_level == `INTC_LEVEL_NMI)
                nmi_on <= 1'b1;
            if (took && irq_level == `INTC_LEVEL_HIGH)
                high_on <= 1'b1;
            if (took && irq_level == `INTC_LEVEL_NORMAL)
                norm_on <= 1'b1;
            if (psel && penable && pready && pwrite && paddr == `INTC_HIGH_VECTOR_SELECT)
                high_chosen <= (pwdata[7:0] != 8'h00);
        end
    end

    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered in the next cycle");
    ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside an access or longer than one cycle");
    err_decode_a: assert property (pready && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > `INTC_LAST_NORMAL))
        else $error("pslverr does not match the address map");
    vector_map_a: assert property (irq_valid |-> (irq_vector - VECTOR_FIRST) < 8'd16 &&
        irq_vector_address == {8'h00, irq_vector} * {8'h00, VECTOR_STEP})
        else $error("vector address does not follow the vector number");
    ack_clears_a: assert property (took |=> !irq_valid)
        else $error("offer still standing after it was taken");
    nmi_alone_a: assert property (nmi_on |-> !irq_valid)
        else $error("offer made while an nmi handler runs");
    normal_wait_a: assert property (nmi_on || high_on || norm_on
        |-> !(irq_valid && irq_level == `INTC_LEVEL_NORMAL))
        else $error("normal offer made while a handler runs");
    high_once_a: assert property (high_on |-> !(irq_valid && irq_level == `INTC_LEVEL_HIGH))
        else $error("high offer made while the high handler runs");
    no_high_a: assert property (!high_chosen && !$past(high_chosen)
        |-> !(irq_valid && irq_level == `INTC_LEVEL_HIGH))
        else $error("high level offered with no source elevated");
    masked_a: assert property (irq_valid && irq_level != `INTC_LEVEL_NMI
        |-> $past(global_int_enable) || $past(global_int_enable, 2))
        else $error("maskable offer made with global enable off");

    nmi_taken_c: cover property (took && irq_level == `INTC_LEVEL_NMI);
    preempt_c: cover property (took && irq_level == `INTC_LEVEL_HIGH && norm_on);
    bus_error_c: cover property (pready && pslverr);
endmodule // intc_properties

bind cpu_interrupt_controller intc_properties #(
    .VECTOR_FIRST(VECTOR_FIRST), .VECTOR_STEP(VECTOR_STEP)
) chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .global_int_enable(global_int_enable), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_vector_address(irq_vector_address), .irq_level(irq_level)
);

// *** testbench/core_model.sv ***
// Behavioural CPU core: takes offered interrupts, returns on request.
// Assumes pclk logic; the bench steers it by accept, slow and ret_req.
`timescale 1ns/10ps

module core_model (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       irq_valid,
    input  wire [7:0] irq_vector,
    input  wire [1:0] irq_level,
    input  wire       accept,
    input  wire       slow,
    input  wire       ret_req,
    output reg        irq_ack,
    output reg        irq_return,
    output reg  [7:0] taken_vector,
    output reg  [1:0] taken_level,
    output reg  [7:0] taken_count
);
    reg [2:0] wait_cnt;

    // Slow mode lets an offer stand a while, so a better one may replace it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack      <= 1'b0;
            irq_return   <= 1'b0;
            taken_vector <= 8'h00;
            taken_level  <= 2'h0;
            taken_count  <= 8'h00;
            wait_cnt     <= 3'h0;
        end else begin
            irq_return <= ret_req;
            if (!irq_valid)
                wait_cnt <= 3'h0;
            else if (wait_cnt != 3'h7)
                wait_cnt <= wait_cnt + 3'h1;
            irq_ack <= accept && irq_valid && !irq_ack && (!slow || wait_cnt >= 3'h3);
            // Only an ack seen with a standing offer counts as taken
            if (irq_ack && irq_valid) begin
                taken_vector <= irq_vector;
                taken_level  <= irq_level;
                taken_count  <= taken_count + 8'h01;
            end
        end
    end
endmodule // core_model

// *** testbench/tb_cpu_interrupt_priority_ctrl.sv ***
// Bench for the interrupt controller: APB tasks plus a core model.
// Assumes the controller, its checker and core_model are compiled first.
`timescale 1ns/10ps
`include "intc_defines.vh"

module tb_cpu_interrupt_priority_ctrl;
    localparam [7:0] VF = 8'h01, VS = 8'h02;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        gie = 1'b0, accept = 1'b0, slow = 1'b0, ret_req = 1'b0;
    logic        pclk, pready, pslverr, irq_ack, irq_return, irq_valid, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic [15:0] req = 16'h0;
    logic [15:0] vaddr;
    logic [7:0]  vec, tvec, tcnt;
    logic [1:0]  lvl, tlvl;
    logic [7:0]  rr_order [4] = '{8'd7, 8'd2, 8'd3, 8'd7};
    int          n_mismatch, checks_done;

    cpu_interrupt_controller #(.NMI_SOURCES(16'h0003), .VECTOR_FIRST(VF),
        .VECTOR_STEP(VS)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_request(req), .global_int_enable(gie),
        .irq_ack(irq_ack), .irq_return(irq_return), .irq_valid(irq_valid),
        .irq_vector(vec), .irq_vector_address(vaddr), .irq_level(lvl));
    core_model cpu (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
        .irq_vector(vec), .irq_level(lvl), .accept(accept), .slow(slow),
        .ret_req(ret_req), .irq_ack(irq_ack), .irq_return(irq_return),
        .taken_vector(tvec), .taken_level(tlvl), .taken_count(tcnt));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task give_up;
        begin
            n_mismatch++;
            complete_run;
        end
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks_done++;
            if (seen !== exp) begin
                n_mismatch++;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // One APB transfer; the request stands until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        begin
            @(posedge pclk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (pready !== 1'b1 && k < 40);
            if (pready !== 1'b1)
                give_up;
            rdata = prdata;
            err   = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check("read data", rdata, exp);
        end
    endtask

    // Let the core take the next offer, then compare what it took
    task take(input logic [7:0] src, input logic [1:0] l);
        int k;
        logic [7:0] n0;
        begin
            n0 = tcnt;
            @(posedge pclk);
            accept <= 1'b1;
            k = 0;
            while (tcnt === n0 && k < 40) begin
                @(posedge pclk);
                k++;
            end
            if (tcnt === n0)
                give_up;
            accept <= 1'b0;
            check("taken vector", tvec, VF + src);
            check("vector address", vaddr, (VF + src) * VS);
            check("taken level", tlvl, l);
        end
    endtask

    task ret;
        begin
            @(posedge pclk);
            ret_req <= 1'b1;
            @(posedge pclk);
            ret_req <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask

    // No offer may appear for n cycles
    task quiet(input int n);
        logic seen;
        begin
            seen = 1'b0;
            repeat (n) begin
                @(posedge pclk);
                if (irq_valid !== 1'b0)
                    seen = 1'b1;
            end
            check("no offer", seen, 1'b0);
        end
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(12'(4 * i), i == 5 ? 32'hf : 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rdata, 32'h0);
        apb(1'b1, `INTC_LEVEL_STATUS, 32'h7);
        rd(`INTC_LEVEL_STATUS, 32'h0);
        // Static order, with the core answering slowly
        apb(1'b1, `INTC_SOURCE_ENABLE, 32'hffff);
        rd(`INTC_SOURCE_ENABLE, 32'hffff);
        gie  <= 1'b1;
        slow <= 1'b1;
        req  <= 16'h0028;
        take(8'd3, `INTC_LEVEL_NORMAL);
        req <= 16'h0020;
        ret;
        take(8'd5, `INTC_LEVEL_NORMAL);
        req <= 16'h0000;
        ret;
        rd(`INTC_LAST_NORMAL, 32'h5);
        slow <= 1'b0;
        // Rotation from last granted 5 over held sources 2, 3 and 7
        apb(1'b1, `INTC_INTERRUPT_CONTROL_A, 32'h1);
        rd(`INTC_INTERRUPT_CONTROL_A, 32'h1);
        req <= 16'h008c;
        for (int i = 0; i < 4; i++) begin
            take(rr_order[i], `INTC_LEVEL_NORMAL);
            ret;
        end
        // Source 6 elevated; rotation stays on, it still pre-empts
        req <= 16'h0000;
        apb(1'b1, `INTC_HIGH_VECTOR_SELECT, {24'h0, VF + 8'd6});
        rd(`INTC_HIGH_VECTOR_SELECT, {24'h0, VF + 8'd6});
        req <= 16'h0010;
        take(8'd4, `INTC_LEVEL_NORMAL);
        req <= 16'h0054;
        take(8'd6, `INTC_LEVEL_HIGH);
        quiet(6);
        rd(`INTC_LEVEL_STATUS, 32'h3);
        req <= 16'h0000;
        ret;
        rd(`INTC_LEVEL_STATUS, 32'h1);
        ret;
        rd(`INTC_LEVEL_STATUS, 32'h0);
        req <= 16'h0044;
        take(8'd6, `INTC_LEVEL_HIGH);
        req <= 16'h0004;
        ret;
        take(8'd2, `INTC_LEVEL_NORMAL);
        req <= 16'h0000;
        ret;
        // Two NMIs and a normal source with global enable off
        gie <= 1'b0;
        req <= 16'h0013;
        take(8'd0, `INTC_LEVEL_NMI);
        rd(`INTC_LEVEL_STATUS, 32'h4);
        gie <= 1'b1;
        quiet(6);
        req <= 16'h0012;
        ret;
        take(8'd1, `INTC_LEVEL_NMI);
        gie <= 1'b0;
        req <= 16'h0010;
        ret;
        quiet(6);
        // An NMI source with its enable clear stays silent
        apb(1'b1, `INTC_SOURCE_ENABLE, 32'hfffe);
        req <= 16'h0001;
        quiet(6);
        apb(1'b1, `INTC_SOURCE_ENABLE, 32'hffff);
        take(8'd0, `INTC_LEVEL_NMI);
        req <= 16'h0000;
        ret;
        complete_run;
    end
endmodule // tb_cpu_interrupt_priority_ctrl
